/* File: bench/roc_ctrl_model.sv */
// Controller model: APB master issuing module register accesses.
// Assumes one clock shared with the block.
`timescale 1ns/1ns
`default_nettype none
module roc_ctrl_model (
	input  wire logic        clk,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [11:0] paddr,
	output var  logic [31:0] pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// Setup, access until pready, then release with scrambled bus
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // roc_ctrl_model
`default_nettype wire

/* File: bench/roc_top_assertions.sv */
// Port-level checks for the relay output configuration block.
// Assumes it is bound into roc_top with TICK_CYCLES handed on.
`timescale 1ns/1ns
`default_nettype none
module roc_top_assertions #(
	parameter integer TICK_CYCLES = 1 // Cycles per ms tick
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	input  wire logic [15:0] relay_out,
	input  wire logic        internal_fault_led,
	input  wire logic        comm_ok_led
);
	// ----------------------------------------
	// Watchdog bounds and access counter
	// ----------------------------------------
	localparam int LO = 62 * TICK_CYCLES * 65 / 100;
	localparam int HI = 16000 * TICK_CYCLES * 135 / 100;
	wire logic acc = psel && penable; // Completing access
	wire logic srd = acc && !pwrite && paddr == 12'h034; // Status read
	int wd_cnt; // Cycles since last access
	// Restart on access, idle while timed out
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			wd_cnt <= 0;
		else if (acc || !comm_ok_led)
			wd_cnt <= 0;
		else
			wd_cnt <= wd_cnt + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_hi_zero;
		srd |-> prdata[31:11] == 21'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("high bits set");
	property p_fuse_off;
		srd && !prdata[7] |-> !prdata[6];
	endproperty
	a_fuse_off: assert property (p_fuse_off) else $error("fuse bit");
	property p_fault;
		!comm_ok_led |-> internal_fault_led;
	endproperty
	a_fault: assert property (p_fault) else $error("fault led off");
	property p_restart;
		acc |=> comm_ok_led;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");
	property p_unmapped;
		acc && !(paddr inside {12'h000, 12'h034, 12'h040, 12'h044})
			|-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no slverr");
	property p_wd_min;
		$fell(comm_ok_led) |-> wd_cnt >= LO;
	endproperty
	a_wd_min: assert property (p_wd_min) else $error("early timeout");
	property p_wd_max;
		comm_ok_led |-> wd_cnt <= HI;
	endproperty
	a_wd_max: assert property (p_wd_max) else $error("late timeout");
	property p_relay;
		acc && pwrite && paddr == 12'h000
			|-> ##2 relay_out == $past(pwdata[15:0], 2);
	endproperty
	a_relay: assert property (p_relay) else $error("relay stale");
endmodule // roc_top_assertions
bind roc_top roc_top_assertions #(.TICK_CYCLES(TICK_CYCLES))
	roc_top_assertions_i (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pslverr, .relay_out, .internal_fault_led,
	.comm_ok_led);
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the relay output configuration block.
// Assumes roc_top, its checker and the controller model are compiled.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        fuse_blown_in = 1'b0;
	logic [2:0]  strap = 3'b001; // Second base style
	logic        psel, penable, pwrite, pready, pslverr, e, irq;
	logic        int_led, ext_led, ok_led;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] relay_out;
	int          bad_count = 0, checks_done = 0, cyc = 0, n, lo, hi;
	int          per[8] = '{16000, 4000, 2000, 1000, 500, 250, 125, 62};
	localparam int TICKS = 2; // Short tick that still divides
	always #50 clk = ~clk;
	roc_ctrl_model roc_ctrl_model_i (.clk, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr);
	roc_top #(.TICK_CYCLES(TICKS)) roc_top_i (.clk, .reset_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .fuse_blown_in,
		.base_type_strap0(strap[0]), .base_type_strap1(strap[1]),
		.base_type_strap2(strap[2]), .relay_out, .internal_fault_led(int_led),
		.external_fault_led(ext_led), .comm_ok_led(ok_led), .irq);
	// ----------------------------------------
	// Compare, access and closing tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		roc_ctrl_model_i.xfer(1'b1, a, d, q, e);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		roc_ctrl_model_i.xfer(1'b0, a, 32'h0, q, e);
		chk(q, exp);
	endtask
	task conclude;
		$display("Mismatches %0d, comparisons %0d", bad_count, checks_done);
		if (bad_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 70000) begin
			bad_count++;
			conclude;
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(12'h034, 32'h100);
		wr(12'h034, 32'hffffffff);
		rd(12'h034, 32'h1bf);
		@(negedge clk);
		chk(int_led, 1'b1);
		wr(12'h034, 32'h0);
		rd(12'h034, 32'h101);
		wr(12'h000, 32'h0000a5c3);
		// Every period select, hold alternating
		for (int k = 0; k < 8; k++) begin
			wr(12'h034, {26'h0, k[0], k[2:0], 2'b01});
			// Let the restart settle before timing
			@(negedge clk);
			n = 0;
			lo = per[k] * TICKS * 65 / 100;
			hi = per[k] * TICKS * 135 / 100;
			while (ok_led === 1'b1 && n < 45000) begin
				@(negedge clk);
				n++;
			end
			chk(n >= lo && n <= hi, 1'b1);
			@(negedge clk);
			chk(relay_out, k[0] ? 16'ha5c3 : 16'h0);
			chk(int_led, 1'b1);
		end
		wr(12'h034, 32'h3);
		rd(12'h000, 32'h0);
		wr(12'h000, 32'h1234);
		wr(12'h034, 32'h1);
		rd(12'h000, 32'h1234);
		fuse_blown_in <= 1'b1;
		rd(12'h034, 32'h101);
		@(negedge clk);
		chk(ext_led, 1'b0);
		wr(12'h044, 32'h2);
		wr(12'h034, 32'h81);
		repeat (4) @(posedge clk);
		rd(12'h034, 32'h1c1);
		@(negedge clk);
		chk({ext_led, irq}, 2'b11);
		rd(12'h040, 32'h3);
		rd(12'h044, 32'h2);
		wr(12'h040, 32'h3);
		@(negedge clk);
		chk(irq, 1'b0);
		rd(12'h040, 32'h0);
		rd(12'h100, 32'h0);
		chk(e, 1'b1);
		conclude;
	end
endmodule // testbench
`default_nettype wire

/* File: logic/roc_consts.vh */
// Constants for the relay output configuration and status block.
// Assumes the includer works in plain Verilog-2005.
`ifndef ROC_CONSTS_VH
`define ROC_CONSTS_VH

// Register indices and byte addresses
`define ROC_CFG_INDEX     12'd13
`define ROC_ADDR_CFG      (`ROC_CFG_INDEX * 12'd4)
`define ROC_ADDR_DATA     12'h000
`define ROC_ADDR_IRQ_STAT 12'h040
`define ROC_ADDR_IRQ_MASK 12'h044

// Field positions of the configuration and status word
`define ROC_B_CONFIGURED  0
`define ROC_B_FORCE_ERR   1
`define ROC_B_TSEL_LO     2
`define ROC_B_TSEL_HI     4
`define ROC_B_HOLD        5
`define ROC_B_FUSE_BLOWN  6
`define ROC_B_FUSE_EN     7
`define ROC_B_BASE_LO     8
`define ROC_B_BASE_HI     10

// Reset values
`define ROC_CFG_RESET     8'h00
`define ROC_DATA_RESET    16'h0000

// Interrupt bits
`define ROC_IRQ_TIMEOUT   0
`define ROC_IRQ_FUSE      1

// Timing: clock rate and millisecond tick
`define ROC_CLK_HZ        10000000
`define ROC_TICK_MS       1
`define ROC_TICK_CYCLES   (`ROC_CLK_HZ / 1000 * `ROC_TICK_MS)

// Nominal watchdog periods in milliseconds
`define ROC_WD_MS_0       14'd16000
`define ROC_WD_MS_1       14'd4000
`define ROC_WD_MS_2       14'd2000
`define ROC_WD_MS_3       14'd1000
`define ROC_WD_MS_4       14'd500
`define ROC_WD_MS_5       14'd250
`define ROC_WD_MS_6       14'd125
`define ROC_WD_MS_7       14'd62

`endif

/* File: logic/roc_spare_unused.v */
// Intentionally minimal: no extra logic lives outside roc_top.
// Assumes nothing; kept empty of modules.
`default_nettype none
`default_nettype wire

/* File: logic/roc_top.v */
// Relay output module configuration/status register and watchdog.
// Assumes an APB master on clk, strap and fuse inputs from pins.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "roc_consts.vh"

module roc_top #(
	parameter integer TICK_CYCLES = `ROC_TICK_CYCLES, // Cycles per ms tick
	parameter integer CHANNELS    = 16                // Relay channels
) (
	input  wire                clk,
	input  wire                reset_n,
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [11:0]         paddr,
	input  wire [31:0]         pwdata,
	output wire                pready,
	output reg  [31:0]         prdata,
	output reg                 pslverr,
	input  wire                fuse_blown_in,
	input  wire                base_type_strap0,
	input  wire                base_type_strap1,
	input  wire                base_type_strap2,
	output reg  [CHANNELS-1:0] relay_out,
	output wire                internal_fault_led,
	output wire                external_fault_led,
	output wire                comm_ok_led,
	output wire                irq
);

	//------------------------------------------------------------
	// Reset release
	//------------------------------------------------------------
	reg        rst_meta;      // First reset stage
	reg        rst_n;         // Released reset used everywhere

	// Asynchronous assert, two-stage release
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	//------------------------------------------------------------
	// Pin synchronisers
	//------------------------------------------------------------
	reg  [3:0] pin_meta;      // First stage, read only by pin_sync
	reg  [3:0] pin_sync;      // Second stage, safe to use
	wire [3:0] pin_raw;       // Fuse and straps gathered
	assign pin_raw = {base_type_strap2, base_type_strap1,
		base_type_strap0, fuse_blown_in};

	// Two flops per pin
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 4'h0;
			pin_sync <= 4'h0;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	//------------------------------------------------------------
	// Bus decode
	//------------------------------------------------------------
	wire access;              // Completing APB transfer
	wire wr;                  // Completing write
	wire rd;                  // Completing read
	wire hit_cfg;             // Configuration/status word
	wire hit_data;            // Relay data word
	wire hit_stat;            // Interrupt status
	wire hit_mask;            // Interrupt mask
	wire mapped;              // Any known register

	assign pready   = 1'b1;                    // Zero wait states
	assign access   = psel & penable;
	assign wr       = access & pwrite;
	assign rd       = access & ~pwrite;
	assign hit_cfg  = (paddr == `ROC_ADDR_CFG);
	assign hit_data = (paddr == `ROC_ADDR_DATA);
	assign hit_stat = (paddr == `ROC_ADDR_IRQ_STAT);
	assign hit_mask = (paddr == `ROC_ADDR_IRQ_MASK);
	assign mapped   = hit_cfg | hit_data | hit_stat | hit_mask;

	//------------------------------------------------------------
	// Configuration register
	//------------------------------------------------------------
	reg        cfg_configured; // Module configured
	reg        cfg_force_err;  // Forced error
	reg  [2:0] cfg_tsel;       // Watchdog period select
	reg        cfg_hold;       // Hold outputs on timeout
	reg        cfg_fuse_en;    // Fuse detection enable
	// Power-up word, sliced per field so reset stays constant
	localparam [7:0] CFG_RST = `ROC_CFG_RESET;

	// Cleared by reset; bit 0 only ever sets
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_configured <= CFG_RST[`ROC_B_CONFIGURED];
			cfg_force_err  <= CFG_RST[`ROC_B_FORCE_ERR];
			cfg_tsel       <= CFG_RST[`ROC_B_TSEL_HI:`ROC_B_TSEL_LO];
			cfg_hold       <= CFG_RST[`ROC_B_HOLD];
			cfg_fuse_en    <= CFG_RST[`ROC_B_FUSE_EN];
		end else if (wr && hit_cfg) begin
			// Once configured, stays so until reset
			cfg_configured <= cfg_configured |
				pwdata[`ROC_B_CONFIGURED];
			cfg_force_err  <= pwdata[`ROC_B_FORCE_ERR];
			cfg_tsel       <= pwdata[`ROC_B_TSEL_HI:`ROC_B_TSEL_LO];
			cfg_hold       <= pwdata[`ROC_B_HOLD];
			cfg_fuse_en    <= pwdata[`ROC_B_FUSE_EN];
		end
	end

	//------------------------------------------------------------
	// Fuse status
	//------------------------------------------------------------
	wire fuse_blown;          // Qualified fuse blown
	reg  fuse_blown_q;        // Previous, for edge detect
	assign fuse_blown = cfg_fuse_en & pin_sync[0];
	assign external_fault_led = fuse_blown;

	//------------------------------------------------------------
	// Watchdog
	//------------------------------------------------------------
	reg  [31:0] presc;        // Cycles within current ms
	reg  [13:0] ms_count;     // Elapsed ms since last access
	reg  [13:0] wd_limit;     // Selected period in ms
	reg         timed_out;    // Controller has gone silent
	wire        tick;         // One-cycle ms enable
	wire        wd_expire;    // One-cycle timeout event

	// Period lookup
	always @* begin
		case (cfg_tsel)
		3'h0: wd_limit = `ROC_WD_MS_0;
		3'h1: wd_limit = `ROC_WD_MS_1;
		3'h2: wd_limit = `ROC_WD_MS_2;
		3'h3: wd_limit = `ROC_WD_MS_3;
		3'h4: wd_limit = `ROC_WD_MS_4;
		3'h5: wd_limit = `ROC_WD_MS_5;
		3'h6: wd_limit = `ROC_WD_MS_6;
		3'h7: wd_limit = `ROC_WD_MS_7;
		default: wd_limit = `ROC_WD_MS_0;
		endcase
	end

	assign tick      = (presc == TICK_CYCLES - 1);
	assign wd_expire = tick & ~timed_out &
		(ms_count == wd_limit - 14'd1);

	// Prescaler and ms counter, restarted by any access
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			presc     <= 32'h0;
			ms_count  <= 14'h0;
			timed_out <= 1'b0;
		end else if (access) begin
			presc     <= 32'h0;
			ms_count  <= 14'h0;
			timed_out <= 1'b0;
		end else begin
			// Divider, one tick per millisecond
			if (tick) begin
				presc <= 32'h0;
			end else begin
				presc <= presc + 32'h1;
			end
			// Count ms until the limit, then latch silence
			if (wd_expire) begin
				timed_out <= 1'b1;
				ms_count  <= 14'h0;
			end else if (tick && !timed_out) begin
				ms_count  <= ms_count + 14'h1;
			end
		end
	end

	assign internal_fault_led = cfg_force_err | timed_out;
	assign comm_ok_led        = ~timed_out;

	//------------------------------------------------------------
	// Relay data register and outputs
	//------------------------------------------------------------
	reg [CHANNELS-1:0] out_data; // Last commanded relay states

	// Writes accepted even under forced error
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_data <= {CHANNELS{1'b0}}; // All relays off
		end else if (wr && hit_data) begin
			out_data <= pwdata[CHANNELS-1:0];
		end
	end

	// Drive relays, blank on timeout unless holding
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			relay_out <= {CHANNELS{1'b0}}; // All relays off
		end else if (timed_out && !cfg_hold) begin
			relay_out <= {CHANNELS{1'b0}};
		end else if (!timed_out) begin
			relay_out <= out_data;
		end
	end

	//------------------------------------------------------------
	// Interrupts
	//------------------------------------------------------------
	reg  [1:0] irq_stat;      // Sticky events
	reg  [1:0] irq_mask;      // Enables
	wire [1:0] irq_set;       // This cycle's events
	assign irq_set = {fuse_blown & ~fuse_blown_q, wd_expire};
	assign irq     = |(irq_stat & irq_mask);

	// Set wins over write-one-to-clear
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat     <= 2'h0;
			irq_mask     <= 2'h0;
			fuse_blown_q <= 1'b0;
		end else begin
			fuse_blown_q <= fuse_blown;
			if (wr && hit_stat) begin
				irq_stat <= (irq_stat & ~pwdata[1:0]) | irq_set;
			end else begin
				irq_stat <= irq_stat | irq_set;
			end
			if (wr && hit_mask) begin
				irq_mask <= pwdata[1:0];
			end
		end
	end

	//------------------------------------------------------------
	// Read data
	//------------------------------------------------------------
	reg [31:0] rd_mux;        // Selected read word
	reg [31:0] status_word;   // Assembled status

	// Status assembly and read selection
	always @* begin
		status_word = 32'h0;
		status_word[`ROC_B_CONFIGURED] = cfg_configured;
		status_word[`ROC_B_FORCE_ERR]  = cfg_force_err;
		status_word[`ROC_B_TSEL_HI:`ROC_B_TSEL_LO] = cfg_tsel;
		status_word[`ROC_B_HOLD]       = cfg_hold;
		status_word[`ROC_B_FUSE_BLOWN] = fuse_blown;
		status_word[`ROC_B_FUSE_EN]    = cfg_fuse_en;
		status_word[`ROC_B_BASE_HI:`ROC_B_BASE_LO] = pin_sync[3:1];
		rd_mux = 32'h0;
		if (hit_cfg) begin
			rd_mux = status_word;
		end else if (hit_data && !cfg_force_err) begin
			rd_mux[CHANNELS-1:0] = out_data;
		end else if (hit_stat) begin
			rd_mux[1:0] = irq_stat;
		end else if (hit_mask) begin
			rd_mux[1:0] = irq_mask;
		end
	end

	// Registered read data and error
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			// Setup phase captures the answer
			prdata  <= pwrite ? 32'h0 : rd_mux;
			pslverr <= ~mapped;
		end
	end

endmodule // roc_top

`default_nettype wire
